// *** hw/flash_pin_if.sv ***
// Purpose: Pin-level serial front end of a paged serial flash.
// Assumes: Host drives sck well below clk/4; pins are synchronised here.
// Notes:   Array, buffers and opcode execution live outside this block.
`default_nettype none

// ----------------------------------------------------------------
// Receive FIFO
// ----------------------------------------------------------------
module rx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      rd_r;
    logic             full;
    logic             empty;

    assign empty     = (wr_r == rd_r);
    assign full      = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_r[AW-1:0]];

    always_ff @(posedge clk) begin
        if (ce && in_valid && !full) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_r <= '0;
            rd_r <= '0;
        end else if (ce) begin
            if (in_valid && !full) begin
                wr_r <= wr_r + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule : rx_fifo

module flash_pin_if #(
    parameter int NSECT = flash_pin_pkg::NUM_SECT
) (
    // System
    input  wire logic                        clk,
    input  wire logic                        resetn,
    input  wire logic                        ce,
    // Serial pins
    input  wire logic                        cs_n,
    input  wire logic                        sck,
    input  wire logic                        si,
    output logic                             so,
    output logic                             so_oe_n,
    input  wire logic                        wp_n,
    input  wire logic                        reset_pin_n,
    // Configuration and protection
    input  wire logic                        page512_strap,
    input  wire logic                        sw_prot_en,
    input  wire logic                        spr_wr,
    input  wire logic [NSECT-1:0]            spr_wr_data,
    output logic                             spr_refused,
    output logic      [NSECT-1:0]            sect_prot,
    output logic      [NSECT-1:0]            sect_locked,
    output logic                             page_512,
    // Array side status
    input  wire logic                        array_busy,
    output logic                             selected,
    output logic                             standby,
    output logic                             abort,
    // Decoded command
    output flash_pin_pkg::cmd_t              cmd,
    output logic                             cmd_valid,
    output logic                             cmd_refused,
    // Received data stream
    output logic      [flash_pin_pkg::BYTE_W-1:0] rx_data,
    output logic                             rx_valid,
    input  wire logic                        rx_ready,
    output logic                             rx_room,
    output logic                             rx_overrun,
    // Transmit data
    input  wire logic [flash_pin_pkg::BYTE_W-1:0] tx_data,
    output logic                             tx_take
);
    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    flash_pin_pkg::pins_t p1_r, p2_r, p3_r;
    flash_pin_pkg::frame_st_t st_r;
    logic       sel, sck_rise, sck_fall, wp_on, push_w, byte_done;
    logic [2:0] bit_cnt_r, tx_cnt_r;
    logic [1:0] idx_r;
    logic [7:0] sh_r, tx_sh_r, byte_w;
    logic [15:0] addr_r;
    logic [23:0] full_addr;
    logic       refused_r, so_r, strap_done_r;
    logic [NSECT-1:0] spr_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_r <= '1;
            p2_r <= '1;
            p3_r <= '1;
        end else if (ce) begin
            p1_r <= '{cs_n, sck, si, wp_n, reset_pin_n};
            p2_r <= p1_r;
            p3_r <= p2_r;
        end
    end

    assign sel      = !p2_r.cs_n && p2_r.rst_n;
    assign sck_rise = sel && p2_r.sck && !p3_r.sck;
    // In mode 3 the clock idles high, so a fall before the first rise is skipped.
    assign sck_fall = sel && !p2_r.sck && p3_r.sck && (st_r == flash_pin_pkg::ST_DATA);
    assign wp_on    = !p2_r.wp_n;
    assign byte_w   = {sh_r[6:0], p2_r.si};
    assign byte_done = sck_rise && (bit_cnt_r == 3'd7);
    assign full_addr = {addr_r, byte_w};
    assign push_w   = byte_done && (st_r == flash_pin_pkg::ST_DATA) && !refused_r
                      && cmd.prog_erase;

    // ----------------------------------------------------------------
    // Frame sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_r      <= flash_pin_pkg::ST_IDLE;
            bit_cnt_r <= 3'd0;
            idx_r     <= 2'd0;
        end else if (ce) begin
            if (!sel) begin
                st_r      <= flash_pin_pkg::ST_IDLE;
                bit_cnt_r <= 3'd0;
                idx_r     <= 2'd0;
            end else begin
                if (sck_rise) begin
                    bit_cnt_r <= bit_cnt_r + 3'd1;
                end
                unique case (st_r)
                    flash_pin_pkg::ST_IDLE: st_r <= flash_pin_pkg::ST_OPC;
                    flash_pin_pkg::ST_OPC: begin
                        if (byte_done) begin
                            st_r <= flash_pin_pkg::ST_ADDR;
                        end
                    end
                    flash_pin_pkg::ST_ADDR: begin
                        if (byte_done) begin
                            idx_r <= idx_r + 2'd1;
                            if (idx_r == 2'(flash_pin_pkg::ADDR_BYTES - 1)) begin
                                st_r <= flash_pin_pkg::ST_DATA;
                            end
                        end
                    end
                    flash_pin_pkg::ST_DATA: st_r <= flash_pin_pkg::ST_DATA;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sh_r   <= 8'h00;
            addr_r <= 16'h0000;
        end else if (ce && sck_rise) begin
            sh_r <= byte_w;
            if (byte_done && st_r == flash_pin_pkg::ST_ADDR) begin
                addr_r <= {addr_r[7:0], byte_w};
            end
        end
    end

    // ----------------------------------------------------------------
    // Command decode and protection
    // ----------------------------------------------------------------
    localparam int PAGE_W_L = flash_pin_pkg::PAGE_W;
    logic [PAGE_W_L-1:0] page_w;
    logic pe_w, lock_hit_w;

    // Binary pages drop one byte-address bit. Array is 4096 pages.
    assign page_w = page_512 ? full_addr[20:9] : full_addr[21:10];
    assign pe_w   = (cmd.opcode[7:4] == flash_pin_pkg::PE_OP_HI);
    assign lock_hit_w = sect_locked[page_w[PAGE_W_L-1 -: $clog2(NSECT)]];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd         <= '0;
            cmd_valid   <= 1'b0;
            cmd_refused <= 1'b0;
            refused_r   <= 1'b0;
        end else if (ce) begin
            cmd_valid   <= 1'b0;
            cmd_refused <= 1'b0;
            if (!sel) begin
                refused_r <= 1'b0;
            end else if (byte_done && st_r == flash_pin_pkg::ST_OPC) begin
                cmd.opcode <= byte_w;
            end else if (byte_done && st_r == flash_pin_pkg::ST_ADDR
                         && idx_r == 2'(flash_pin_pkg::ADDR_BYTES - 1)) begin
                cmd.page       <= page_w;
                cmd.byte_addr  <= page_512 ? {1'b0, full_addr[8:0]} : full_addr[9:0];
                cmd.prog_erase <= pe_w;
                // Ignored until deselect; the array keeps running undisturbed.
                if (pe_w && (wp_on || lock_hit_w)) begin
                    refused_r   <= 1'b1;
                    cmd_refused <= 1'b1;
                end else begin
                    cmd_valid <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            spr_r       <= flash_pin_pkg::SPR_RESET;
            spr_refused <= 1'b0;
            sect_locked <= '0;
        end else if (ce) begin
            spr_refused <= spr_wr && wp_on;
            if (spr_wr && !wp_on) begin
                spr_r <= spr_wr_data;
            end
            sect_locked <= spr_r & {NSECT{wp_on || sw_prot_en}};
        end
    end
    assign sect_prot = spr_r;

    // Strap is caught once after reset release, never by the reset itself.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_done_r <= 1'b0;
            page_512     <= 1'b0;
        end else if (ce && !strap_done_r) begin
            strap_done_r <= 1'b1;
            page_512     <= page512_strap;
        end
    end

    // ----------------------------------------------------------------
    // Serial output and status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            so_r     <= 1'b0;
            tx_sh_r  <= 8'h00;
            tx_cnt_r <= 3'd0;
            tx_take  <= 1'b0;
        end else if (ce) begin
            tx_take <= 1'b0;
            if (!sel) begin
                tx_cnt_r <= 3'd0;
            end else if (sck_fall) begin
                tx_cnt_r <= tx_cnt_r + 3'd1;
                if (tx_cnt_r == 3'd0) begin
                    so_r    <= tx_data[7];
                    tx_sh_r <= {tx_data[6:0], 1'b0};
                    tx_take <= 1'b1;
                end else begin
                    so_r    <= tx_sh_r[7];
                    tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                end
            end
        end
    end
    assign so = so_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            so_oe_n    <= 1'b1;
            selected   <= 1'b0;
            standby    <= 1'b0;
            abort      <= 1'b0;
            rx_overrun <= 1'b0;
        end else if (ce) begin
            so_oe_n    <= !sel;
            selected   <= sel;
            standby    <= !sel && !array_busy;
            abort      <= !p2_r.rst_n;
            rx_overrun <= push_w && !rx_room;
        end
    end

    rx_fifo #(
        .WIDTH (flash_pin_pkg::BYTE_W),
        .DEPTH (flash_pin_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .in_valid  (push_w),
        .in_ready  (rx_room),
        .in_data   (byte_w),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_so_release;
        ce && p2_r.cs_n |=> so_oe_n;
    endproperty
    a_so_release: assert property (p_so_release) else $error("output driven deselected");

    property p_si_ignored;
        ce && !sel |=> $stable(sh_r) && $stable(cmd);
    endproperty
    a_si_ignored: assert property (p_si_ignored) else $error("input used deselected");

    property p_discard;
        ce && p2_r.cs_n |=> st_r == flash_pin_pkg::ST_IDLE && bit_cnt_r == 3'd0;
    endproperty
    a_discard: assert property (p_discard) else $error("partial frame kept");

    property p_refuse_no_data;
        refused_r |-> !push_w && !cmd_valid;
    endproperty
    a_refuse_no_data: assert property (p_refuse_no_data) else $error("refused op ran");

    property p_spr_hold;
        ce && spr_wr && wp_on |=> spr_refused && $stable(sect_prot);
    endproperty
    a_spr_hold: assert property (p_spr_hold) else $error("map changed under protect");

    property p_busy_no_standby;
        ce && array_busy |=> !standby;
    endproperty
    a_busy_no_standby: assert property (p_busy_no_standby) else $error("standby while busy");

    property p_so_on_fall;
        ce && !sck_fall |=> $stable(so_r);
    endproperty
    a_so_on_fall: assert property (p_so_on_fall) else $error("output moved off fall");

    property p_sample_rise;
        ce && sck_rise |=> sh_r[0] == $past(p2_r.si);
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("input not sampled");

    property p_reset_pin;
        ce && !p2_r.rst_n |=> abort && st_r == flash_pin_pkg::ST_IDLE;
    endproperty
    a_reset_pin: assert property (p_reset_pin) else $error("reset pin not honoured");

    property p_hw_lock;
        ce && wp_on |=> sect_locked == $past(sect_prot);
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("sectors not locked");

    c_cmd:     cover property (cmd_valid);
    c_refused: cover property (cmd_refused);
    c_push:    cover property (push_w);
    c_spr_ref: cover property (spr_refused);
endmodule : flash_pin_if
`default_nettype wire

// *** pkg/flash_pin_pkg.sv ***
// Purpose: Shared constants and types for the serial flash pin front end.
// Assumes: One 50 MHz system clock; pins arrive asynchronously.
// Notes:   Opcode class and sector split are local conventions.
`default_nettype none
package flash_pin_pkg;
    localparam int CLK_MHZ      = 50;
    localparam int SYNC_STAGES  = 2;
    localparam int BYTE_W       = 8;
    localparam int ADDR_BYTES   = 3;
    localparam int FIFO_DEPTH   = 8;
    localparam int NUM_PAGES    = 4096;
    localparam int NUM_BUFS     = 2;
    localparam int PAGE_STD     = 528;
    localparam int PAGE_BIN     = 512;
    localparam int PAGE_W       = 12;
    localparam int BADDR_W      = 10;
    localparam int NUM_SECT     = 16;
    // Security area: 64 bytes factory identifier plus 64 bytes user space.
    localparam int OTP_BYTES    = 128;
    localparam int OTP_FACTORY  = 64;
    localparam logic [3:0] PE_OP_HI = 4'h8;
    localparam logic [NUM_SECT-1:0] SPR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OPC  = 2'b01,
        ST_ADDR = 2'b11,
        ST_DATA = 2'b10
    } frame_st_t;

    typedef struct packed {
        logic [7:0]         opcode;
        logic [PAGE_W-1:0]  page;
        logic [BADDR_W-1:0] byte_addr;
        logic               prog_erase;
    } cmd_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
        logic wp_n;
        logic rst_n;
    } pins_t;
endpackage : flash_pin_pkg
`default_nettype wire

// *** verification/spi_host_model.sv ***
// Purpose: Behavioural host controller that frames and shifts serial traffic.
// Assumes: Link clock period of eight system clocks, changes only at clk edges.
// Notes:   Reads trust the output line only while the device drives it.
`default_nettype none
module spi_host_model (
    // System
    input  wire logic clk,
    // Serial pins
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    input  wire logic so,
    input  wire logic so_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cpol;
    logic last;
    // A released output reads as the inverse of the last bit, never a settled zero.
    wire logic so_w = so_oe_n ? ~last : so;

    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
        cpol = 1'b0;
        last = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk);
    endtask : half

    task automatic begin_frame(input logic mode3);
        cpol = mode3;
        sck  <= mode3;
        half();
        cs_n <= 1'b0;
        half();
    endtask : begin_frame

    task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck <= 1'b0;
            si  <= tx[i];
            half();
            sck   <= 1'b1;
            rx[i] = so_w;
            last  = so_w;
            half();
        end
    endtask : bits

    task automatic end_frame();
        sck <= cpol;
        half();
        cs_n <= 1'b1;
        si   <= ~si;
        half();
    endtask : end_frame
endmodule : spi_host_model
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the serial flash pin front end.
// Assumes: 50 MHz system clock, 160 ns link clock, ce low only in a freeze check.
// Notes:   The array side is reduced to the busy level and the byte streams.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, resetn, ce, cs_n, sck, si, so, so_oe_n, wp_n, reset_pin_n;
    logic        page512_strap, sw_prot_en, spr_wr, spr_refused, page_512;
    logic [15:0] spr_wr_data, sect_prot, sect_locked;
    logic        array_busy, selected, standby, abort, cmd_valid, cmd_refused;
    logic [7:0]  rx_data, tx_data, r;
    logic        rx_valid, rx_ready, rx_room, rx_overrun, tx_take;
    flash_pin_pkg::cmd_t cmd;
    int          n_errors, comparisons, n_val, n_ref, n_ovr, n_take, n_sref;

    spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
                         .so_oe_n(so_oe_n));

    flash_pin_if dut (.clk(clk), .resetn(resetn), .ce(ce), .cs_n(cs_n), .sck(sck),
        .si(si), .so(so), .so_oe_n(so_oe_n), .wp_n(wp_n), .reset_pin_n(reset_pin_n),
        .page512_strap(page512_strap), .sw_prot_en(sw_prot_en), .spr_wr(spr_wr),
        .spr_wr_data(spr_wr_data), .spr_refused(spr_refused), .sect_prot(sect_prot),
        .sect_locked(sect_locked), .page_512(page_512), .array_busy(array_busy),
        .selected(selected), .standby(standby), .abort(abort), .cmd(cmd),
        .cmd_valid(cmd_valid), .cmd_refused(cmd_refused), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_room(rx_room),
        .rx_overrun(rx_overrun), .tx_data(tx_data), .tx_take(tx_take));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Pulses are counted so that a scenario can check how many fired.
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) n_val <= n_val + 1;
        if (cmd_refused === 1'b1) n_ref <= n_ref + 1;
        if (rx_overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (tx_take === 1'b1) n_take <= n_take + 1;
        if (spr_refused === 1'b1) n_sref <= n_sref + 1;
    end

    task automatic end_sim();
        if (n_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic hdr(input logic [7:0] op, input logic [11:0] pg, input logic [9:0] ba);
        logic [23:0] a;
        logic [7:0]  q;
        a = {2'b00, pg, ba};
        host.bits(op, 8, q);
        for (int k = 2; k >= 0; k--) host.bits(a[k*8 +: 8], 8, q);
        // One more edge lets the command pulse reach the counters.
        tick(1);
    endtask : hdr

    initial begin
        #1ms;
        n_errors++;
        end_sim();
    end

    initial begin
        resetn = 1'b0; ce = 1'b1; wp_n = 1'b1; reset_pin_n = 1'b1;
        page512_strap = 1'b0; sw_prot_en = 1'b0; spr_wr = 1'b0;
        spr_wr_data = 16'h0000; array_busy = 1'b0; rx_ready = 1'b0;
        tx_data = 8'hA5;
        tick(20);
        resetn <= 1'b1;
        tick(5);
        check("oe_idle", so_oe_n, 1);
        check("sel_idle", selected, 0);
        check("stby_idle", standby, 1);
        check("page512", page_512, 0);
        // Traffic while deselected must leave no trace.
        for (int k = 0; k < 4; k++) host.bits(8'h82, 8, r);
        tick(4);
        check("desel_cmd", n_val, 0);
        // Mode 0 read-class command with two bytes returned.
        host.begin_frame(1'b0);
        check("sel", selected, 1);
        check("oe_sel", so_oe_n, 0);
        hdr(8'h0B, 12'hA5C, 10'h2F3);
        check("n_val1", n_val, 1);
        check("opc", cmd.opcode, 8'h0B);
        check("page", cmd.page, 12'hA5C);
        check("baddr", cmd.byte_addr, 10'h2F3);
        check("pe0", cmd.prog_erase, 0);
        host.bits(8'hFF, 8, r);
        check("so_byte", r, 8'hA5);
        check("n_take", n_take, 1);
        tx_data <= 8'h69;
        host.bits(8'hFF, 8, r);
        check("so_byte2", r, 8'h69);
        check("n_take2", n_take, 2);
        host.end_frame();
        check("oe_end", so_oe_n, 1);
        check("desel", selected, 0);
        // Mode 3, a partial header is dropped at deselect.
        host.begin_frame(1'b1);
        host.bits(8'h0B, 8, r);
        host.bits(8'h12, 4, r);
        host.end_frame();
        host.begin_frame(1'b1);
        hdr(8'h3C, 12'h001, 10'h001);
        check("n_val2", n_val, 2);
        check("opc2", cmd.opcode, 8'h3C);
        host.end_frame();
        // Program stream overfills the buffer while the consumer stalls.
        host.begin_frame(1'b1);
        hdr(8'h82, 12'h123, 10'h000);
        check("pe1", cmd.prog_erase, 1);
        for (int k = 0; k < 9; k++) host.bits(8'h10 + 8'(k), 8, r);
        tick(1);
        check("room", rx_room, 0);
        check("n_ovr", n_ovr, 1);
        array_busy <= 1'b1;
        host.end_frame();
        check("stby_busy", standby, 0);
        check("desel_busy", selected, 0);
        for (int k = 0; k < 8; k++) begin
            check("rx_v", rx_valid, 1);
            check("rx_d", rx_data, 8'h10 + 8'(k));
            rx_ready <= 1'b1;
            tick(1);
            rx_ready <= 1'b0;
            tick(1);
        end
        check("rx_empty", rx_valid, 0);
        array_busy <= 1'b0;
        tick(3);
        check("stby_done", standby, 1);
        // Protection map and its two independent paths.
        spr_wr_data <= 16'h0002;
        spr_wr <= 1'b1;
        tick(1);
        spr_wr <= 1'b0;
        tick(3);
        check("map", sect_prot, 16'h0002);
        // With the clock enable low a write pulse must leave no trace.
        ce <= 1'b0;
        spr_wr_data <= 16'h0004;
        spr_wr <= 1'b1;
        tick(1);
        spr_wr <= 1'b0;
        tick(3);
        ce <= 1'b1;
        check("map_frozen", sect_prot, 16'h0002);
        check("lock_off", sect_locked, 16'h0000);
        sw_prot_en <= 1'b1;
        tick(3);
        check("lock_sw", sect_locked, 16'h0002);
        sw_prot_en <= 1'b0;
        wp_n <= 1'b0;
        tick(5);
        check("lock_hw", sect_locked, 16'h0002);
        spr_wr_data <= 16'hFFFF;
        spr_wr <= 1'b1;
        tick(1);
        spr_wr <= 1'b0;
        tick(3);
        check("map_held", sect_prot, 16'h0002);
        check("n_sref", n_sref, 1);
        // Program under the protect line is refused and takes no data.
        host.begin_frame(1'b0);
        hdr(8'h81, 12'h700, 10'h000);
        host.bits(8'h5A, 8, r);
        host.end_frame();
        check("n_ref1", n_ref, 1);
        check("n_val3", n_val, 3);
        check("rx_none", rx_valid, 0);
        wp_n <= 1'b1;
        sw_prot_en <= 1'b1;
        host.begin_frame(1'b0);
        hdr(8'h83, 12'h1F0, 10'h000);
        host.end_frame();
        check("n_ref2", n_ref, 2);
        sw_prot_en <= 1'b0;
        // Reset pin in mid-frame.
        host.begin_frame(1'b0);
        host.bits(8'h0B, 8, r);
        reset_pin_n <= 1'b0;
        tick(5);
        check("abort", abort, 1);
        check("oe_abort", so_oe_n, 1);
        reset_pin_n <= 1'b1;
        host.end_frame();
        check("abort_end", abort, 0);
        // Strapped page size after a second reset.
        resetn <= 1'b0;
        page512_strap <= 1'b1;
        tick(3);
        resetn <= 1'b1;
        tick(4);
        check("page512_st", page_512, 1);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
